// ===== rtl/ics_pkg.sv
// Purpose: Shared constants and types for the input clock auto selector
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`default_nettype none
package ics_pkg;
    // Register byte offsets
    localparam logic [7:0] ICS_CTRL_OFS = 8'h00;
    localparam logic [7:0] ICS_PRIO_OFS = 8'h04;
    localparam logic [7:0] ICS_STAT_OFS = 8'h08;
    localparam logic [7:0] ICS_LOCK_OFS = 8'h0C;
    localparam logic [7:0] ICS_PH0_OFS = 8'h10; // Four phase words follow
    // Control field positions
    localparam int ICS_MODE_POS = 0; // Two bits
    localparam int ICS_MSEL_POS = 2; // Two bits
    localparam int ICS_PAIR_POS = 4;
    localparam int ICS_FRUN_POS = 5;
    localparam int ICS_FOSEN_POS = 6;
    localparam int ICS_VALT_POS = 8; // Two bits
    // Reset values
    localparam logic [9:0] ICS_CTRL_RST = 10'h142; // Revertive, fos on, input_validation_time 01
    localparam logic [7:0] ICS_PRIO_RST = 8'hE4; // Slots 1..4 -> inputs 1..4
    localparam logic [1:0] ICS_SEL_RST = 2'h0; // Input 1
    localparam logic [1:0] ICS_VALT_HITLESS = 2'h1; // Least hitless validation time
    localparam int ICS_PH_W = 16; // Phase word width
    // Selection modes
    typedef enum logic [1:0]
    {
        ICS_MANUAL = 2'h0,
        ICS_AUTO_NONREV = 2'h1,
        ICS_AUTO_REV = 2'h2,
        ICS_RESERVED = 2'h3
    } ics_mode_t;
    // Alarm carrier for the four inputs
    typedef struct packed
    {
        logic [3:0] los; // Signal loss per input
        logic [3:0] fos; // Frequency offset per input
    } ics_alarm_t;
endpackage
`default_nettype wire

// ===== rtl/ics_selector.sv
// Purpose: Automatic input clock selection with phase build-out and hold
// Assumes: Alarm pins are asynchronous; phase words come from pclk logic
// Notes: Registers over APB; selection re-evaluated every cycle
//
// Summary of operation
// - Priority code 00..11 names inputs 1..4
// - Pairing uses slots 1,2 only, pairs
// - Default priority selects input 1 first
// - Input 1 alarmed, input 2 clean: take 2
// - Fall through priority to inputs 3, 4
// - All four alarmed: enter digital hold
// - Disabled offset alarms never cause switch
// - Signal-loss alarms count, except input 2's in free run
// - Non-revertive keeps valid lower input
// - Track every path's phase offset continuously
// - Lock new input at its own offset
// - Hitless only when validation time >= 01
// - Free run routes oscillator over input 2
// - Free run status follows the oscillator
// - Free run: use 1, fall back, return
// - Hold when every path has an alarm that counts
// - Mode 00 manual, 01 nonrev, 10 rev
// - Manual select ignored in automatic modes
`default_nettype none
module ics_selector
    import ics_pkg::*;
(
    input wire logic pclk, // 200 MHz bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire ics_alarm_t alarm_pin, // Raw per-input alarms
    input wire logic osc_loss_alarm, // Raw oscillator loss alarm
    input wire logic cal_done, // Self-calibration finished
    input wire logic [4*ICS_PH_W-1:0] phase_in, // Per-input phase words
    input wire logic [ICS_PH_W-1:0] osc_phase, // Oscillator phase word
    output logic [1:0] ref_sel, // Active input index
    output logic hold_active, // Digital hold
    output logic osc_route, // Mux: oscillator replaces input 2
    output logic second_input_status_pin, // Input 2 path alarm
    output logic [ICS_PH_W-1:0] pd_offset, // Offset loaded at switch
    output logic hitless_ok // Last switch was hitless
);
    // Alarm synchronisers, two stages each
    ics_alarm_t al_s1_q;
    ics_alarm_t al_s2_q;
    logic osc_s1_q;
    logic osc_s2_q;
    // Configuration registers
    logic [9:0] ctrl_q;
    logic [7:0] prio_q;
    // Selection state
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    logic hold_q;
    logic hold_d;
    logic [ICS_PH_W-1:0] off_q;
    logic hit_q;
    logic [7:0] swcnt_q; // Switch counter, wraps
    // Phase tracking, one word per input
    logic [ICS_PH_W-1:0] ph_q [4];
    logic [ICS_PH_W-1:0] ph_now [4]; // Live phase per path
    // Derived signals
    ics_mode_t mode;
    logic pair;
    logic frun;
    logic [3:0] bad; // Effective alarm per input
    logic [1:0] best; // Highest-priority clean input
    logic any_ok; // Some candidate is clean
    logic [31:0] rd_d;
    logic map_ok;
    logic wr_en;
    // Field extraction
    assign mode = ics_mode_t'(ctrl_q[ICS_MODE_POS +: 2]);
    assign pair = ctrl_q[ICS_PAIR_POS];
    assign frun = ctrl_q[ICS_FRUN_POS];

    // Two-flop sync; first stage read only by second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            al_s1_q <= '0;
            al_s2_q <= '0;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
        end
        else
        begin
            al_s1_q <= alarm_pin;
            al_s2_q <= al_s1_q;
            osc_s1_q <= osc_loss_alarm;
            osc_s2_q <= osc_s1_q;
        end
    end

    // Effective alarm per input
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            // Loss always counts, offset only when enabled
            bad[i] = al_s2_q.los[i] | (al_s2_q.fos[i] & ctrl_q[ICS_FOSEN_POS]);
        end
        // Free run: input 2 path carries the oscillator
        if (frun)
        begin
            bad[1] = osc_s2_q;
        end
    end

    // Priority walk over the slots
    always_comb
    begin
        best = ICS_SEL_RST;
        any_ok = 1'b0;
        // Walk slots from lowest priority upward so slot 1 wins
        for (int k = 3; k >= 0; k--)
        begin
            // Pairing: slots 3, 4 ignored, codes 10/11 unused
            if (!(pair && (k > 1)) && !(pair && prio_q[2*k+1]))
            begin
                // Slot code is the input index directly
                if (!bad[prio_q[2*k +: 2]])
                begin
                    best = prio_q[2*k +: 2];
                    any_ok = 1'b1;
                end
            end
        end
    end

    // Next selection and hold decision
    always_comb
    begin
        sel_d = sel_q;
        hold_d = hold_q;
        unique case (mode)
            // Manual: hold if the chosen input is alarmed
            ICS_MANUAL:
            begin
                sel_d = ctrl_q[ICS_MSEL_POS +: 2];
                hold_d = cal_done & bad[sel_d];
            end
            // Keep current while valid
            ICS_AUTO_NONREV:
            begin
                // Manual field not consulted here
                if (bad[sel_q] || hold_q || (pair && sel_q[1]))
                begin
                    sel_d = any_ok ? best : sel_q;
                end
                hold_d = cal_done & ~any_ok;
            end
            // Always take the best clean input
            ICS_AUTO_REV:
            begin
                sel_d = any_ok ? best : sel_q;
                hold_d = cal_done & ~any_ok;
            end
            // Reserved code: freeze where we are
            ICS_RESERVED:
            begin
                sel_d = sel_q;
                hold_d = hold_q;
            end
        endcase
    end

    // Selection registers change only on the edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_q <= ICS_SEL_RST;
            hold_q <= 1'b0;
        end
        else
        begin
            sel_q <= sel_d;
            hold_q <= hold_d;
        end
    end

    // Live phase per path; build-out reads this so that a switch made
    // in the cycle free run starts already sees the oscillator
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            ph_now[i] = phase_in[i*ICS_PH_W +: ICS_PH_W];
        end
        if (frun)
        begin
            ph_now[1] = osc_phase;
        end
    end

    // Phase tracking of every input, oscillator on path 2
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                ph_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                ph_q[i] <= ph_now[i];
            end
        end
    end

    // Phase build-out on a switch or hold exit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            off_q <= '0;
            hit_q <= 1'b1;
            swcnt_q <= 8'h00;
        end
        else if ((sel_d != sel_q) || (hold_q && !hold_d))
        begin
            swcnt_q <= swcnt_q + 8'h01;
            // Short validation time cannot promise a clean switch
            if (ctrl_q[ICS_VALT_POS +: 2] >= ICS_VALT_HITLESS)
            begin
                off_q <= ph_now[sel_d];
                hit_q <= 1'b1;
            end
            else
            begin
                off_q <= '0;
                hit_q <= 1'b0;
            end
        end
    end

    // Pin-facing outputs straight from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_sel <= ICS_SEL_RST;
            hold_active <= 1'b0;
            osc_route <= 1'b0;
            second_input_status_pin <= 1'b0;
            pd_offset <= '0;
            hitless_ok <= 1'b1;
        end
        else
        begin
            ref_sel <= sel_q;
            hold_active <= hold_q;
            osc_route <= frun;
            second_input_status_pin <= bad[1];
            pd_offset <= off_q;
            hitless_ok <= hit_q;
        end
    end

    // Bus decode; no wait state, ready in the first access cycle
    assign wr_en = psel & penable & pready & pwrite & map_ok;
    always_comb
    begin
        map_ok = 1'b1;
        rd_d = 32'h0000_0000;
        unique case (paddr)
            ICS_CTRL_OFS: rd_d[9:0] = ctrl_q;
            ICS_PRIO_OFS: rd_d[7:0] = prio_q;
            ICS_STAT_OFS: rd_d = {8'h00, swcnt_q, bad, hit_q, hold_q, sel_q,
                al_s2_q.los, al_s2_q.fos};
            ICS_LOCK_OFS: rd_d[ICS_PH_W-1:0] = off_q;
            default:
            begin
                // Phase words, one per input
                if ((paddr[7:4] == ICS_PH0_OFS[7:4]) && (paddr[1:0] == 2'h0))
                begin
                    rd_d[ICS_PH_W-1:0] = ph_q[paddr[3:2]];
                end
                else
                begin
                    map_ok = 1'b0;
                end
            end
        endcase
    end

    // Ready rises in access phase; data latched in setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            pready <= 1'b1;
            pslverr <= ~map_ok;
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Configuration writes; software owns the setup order
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= ICS_CTRL_RST;
            prio_q <= ICS_PRIO_RST;
        end
        else if (wr_en)
        begin
            // Free run must follow divider setup elsewhere
            if (paddr == ICS_CTRL_OFS)
            begin
                ctrl_q <= pwdata[9:0];
            end
            if (paddr == ICS_PRIO_OFS)
            begin
                prio_q <= pwdata[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/ics_selector_chk.sv
// Purpose: Concurrent checks on the selector's ports
// Assumes: Control words are shadowed from committed APB writes
// Notes: Selection checks wait for six calm cycles, as pins lag four edges
`default_nettype none
module ics_selector_chk
    import ics_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Write
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire ics_alarm_t alarm_pin, // Alarms
    input wire logic osc_loss_alarm, // Osc alarm
    input wire logic cal_done, // Calibrated
    input wire logic [4*ICS_PH_W-1:0] phase_in, // Phases
    input wire logic [ICS_PH_W-1:0] osc_phase, // Osc phase
    input wire logic [1:0] ref_sel, // Selection
    input wire logic hold_active, // Hold
    input wire logic second_input_status_pin, // Path 2 alarm
    input wire logic [ICS_PH_W-1:0] pd_offset, // Offset
    input wire logic hitless_ok // Hitless
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] ctrl_q; // Shadow control
    logic [7:0] prio_q; // Shadow priority
    logic [9:0] pins_q; // Last pins
    logic [3:0] quiet_q; // Calm cycles, saturating
    logic wr, calm, frun, rev, auto_m; // Decodes
    logic [3:0] raw, eff; // Alarms that count
    logic [1:0] first; // First clean input
    logic [ICS_PH_W-1:0] exp_ph; // Phase of selection
    assign wr = psel && penable && pready && pwrite;
    assign frun = ctrl_q[ICS_FRUN_POS];
    assign raw = alarm_pin.los | (alarm_pin.fos & {4{ctrl_q[ICS_FOSEN_POS]}});
    assign eff = frun ? {raw[3:2], osc_loss_alarm, raw[0]} : raw; // Oscillator owns path 2
    assign calm = quiet_q >= 4'h6 && cal_done; // Outputs settled, margin of two
    assign auto_m = ctrl_q[1] ^ ctrl_q[0];
    assign rev = calm && ctrl_q[1:0] == 2'h2 && !ctrl_q[ICS_PAIR_POS];
    assign first = !eff[0] ? 2'h0 : !eff[1] ? 2'h1 : !eff[2] ? 2'h2 : 2'h3;
    assign exp_ph = (frun && ref_sel == 2'h1) ? osc_phase : phase_in[ref_sel*ICS_PH_W +: ICS_PH_W];
    // Shadow follows writes at their commit edge only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= ICS_CTRL_RST;
            prio_q <= ICS_PRIO_RST;
        end
        else if (wr && paddr == ICS_CTRL_OFS)
            ctrl_q <= pwdata[9:0];
        else if (wr && paddr == ICS_PRIO_OFS)
            prio_q <= pwdata[7:0];
    end
    // Any write or pin change restarts the calm count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins_q <= 10'h000;
            quiet_q <= 4'h0;
        end
        else
        begin
            pins_q <= {cal_done, osc_loss_alarm, alarm_pin};
            if (wr || pins_q != {cal_done, osc_loss_alarm, alarm_pin})
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hF)
                quiet_q <= quiet_q + 4'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A selection change outside hold in an automatic mode
    sequence sw_new;
        $changed(ref_sel) && !hold_active && auto_m;
    endsequence
    chk_prio_map: assert property (rev && !eff[prio_q[1:0]] |-> ref_sel == prio_q[1:0])
        else $error("top slot not chosen");
    chk_rev_first: assert property (rev && prio_q == ICS_PRIO_RST && eff != 4'hF
        |-> ref_sel == first && !hold_active) else $error("wrong revertive pick");
    chk_all_hold: assert property (calm && auto_m && !ctrl_q[ICS_PAIR_POS] && eff == 4'hF
        |-> hold_active) else $error("no hold with all alarmed");
    chk_nonrev_valid: assert property (calm && ctrl_q[1:0] == 2'h1 && eff != 4'hF
        && !ctrl_q[ICS_PAIR_POS] && prio_q == ICS_PRIO_RST
        |-> !eff[ref_sel] && !hold_active) else $error("alarmed input kept");
    chk_status_osc: assert property (calm && frun |-> second_input_status_pin == osc_loss_alarm)
        else $error("status pin not on oscillator");
    chk_offset_load: assert property (sw_new ##0 ctrl_q[9:8] != 2'h0
        |-> pd_offset == exp_ph && hitless_ok) else $error("offset not loaded");
    chk_valt_zero: assert property (sw_new ##0 ctrl_q[9:8] == 2'h0
        |-> pd_offset == '0 && !hitless_ok) else $error("hitless at zero validation");
    chk_sel_calm: assert property (calm && !psel |=> $stable(ref_sel) && $stable(hold_active))
        else $error("selection moved while calm");
endmodule
`default_nettype wire

// ===== verification/ics_selector_tb.sv
// Purpose: Self-checking bench for the input clock auto selector
// Assumes: Ready comes after setup; pins reach outputs within four edges
// Notes: Step word is ctrl, prio, los, fos, then {osc, hold, sel}
`default_nettype none
module ics_selector_tb
    import ics_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_req, cal_done; // Bus, pins
    logic [7:0] paddr; // Address
    logic [31:0] pwdata, prdata, rd; // Data
    logic [3:0] los_req, fos_req; // Fault requests
    ics_alarm_t alarm_pin; // Alarm lines
    logic osc_loss_alarm, hold_active, osc_route, second_input_status_pin, hitless_ok; // Pins
    logic [1:0] ref_sel; // Selection
    logic [4*ICS_PH_W-1:0] phase_in; // Phases
    logic [ICS_PH_W-1:0] osc_phase, pd_offset; // Phase words
    int n_fail = 0; // Mismatches
    int checks_done = 0; // Comparisons
    int cycles = 0; // Hang guard
    ics_selector u_ics_selector (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .alarm_pin, .osc_loss_alarm, .cal_done, .phase_in,
        .osc_phase, .ref_sel, .hold_active, .osc_route, .second_input_status_pin, .pd_offset,
        .hitless_ok);
    ics_src_model u_ics_src_model (.los_req, .fos_req, .osc_req, .alarm_pin, .osc_loss_alarm,
        .phase_in, .osc_phase);
    // 200 MHz clock
    initial
    begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    // Run needs about 350 cycles; a hang ends here
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail++;
            finish_test;
        end
    end
    task finish_test;
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // One transfer; unmapped places must answer with an error
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Access phase stands until ready; only the hang guard ends a wait
        @(posedge pclk);
        while (pready !== 1'h1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        chk(pslverr, a > 8'h1C);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Configure, apply faults, let the pipeline settle, compare
    task automatic st(input logic [31:0] v);
        apb(1'h1, ICS_CTRL_OFS, {20'h0, v[31:20]});
        apb(1'h1, ICS_PRIO_OFS, {24'h0, v[19:12]});
        @(posedge pclk);
        los_req <= v[11:8];
        fos_req <= v[7:4];
        osc_req <= v[3];
        repeat (8) @(posedge pclk);
        chk(hold_active, v[2]);
        if (!v[2])
            chk(ref_sel, v[1:0]);
    endtask
    initial
    begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cal_done = 1'h0;
        los_req = 4'h0;
        fos_req = 4'h0;
        osc_req = 1'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        cal_done <= 1'h1;
        @(posedge pclk);
        chk(ref_sel, 2'h0);
        apb(1'h0, ICS_CTRL_OFS, 32'h0);
        chk(rd, ICS_CTRL_RST);
        apb(1'h0, ICS_PRIO_OFS, 32'h0);
        chk(rd, ICS_PRIO_RST);
        apb(1'h0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, ICS_PH0_OFS + 8'h04, 32'h0);
        chk(rd, 32'h0000_2222);
        st(32'h14E_E4_0_0_0);
        st(32'h14E_E4_1_0_1);
        chk(pd_offset, 16'h2222);
        chk(hitless_ok, 1'h1);
        st(32'h14E_E4_3_0_2);
        st(32'h14E_E4_3_4_3);
        st(32'h14E_E4_B_4_4);
        st(32'h14E_E4_0_1_1);
        st(32'h10E_E4_0_1_0);
        st(32'h10E_E4_1_1_1);
        st(32'h14D_E4_1_0_1);
        st(32'h14D_E4_0_0_1);
        st(32'h142_1B_0_0_3);
        st(32'h142_1B_8_0_2);
        st(32'h152_F1_0_0_1);
        st(32'h152_F1_2_0_0);
        st(32'h152_F1_3_0_4);
        st(32'h162_E4_E_0_0);
        chk(osc_route, 1'h1);
        chk(second_input_status_pin, 1'h0);
        st(32'h162_E4_F_0_1);
        chk(pd_offset, 16'h5A5A);
        st(32'h162_E4_F_0_C);
        chk(second_input_status_pin, 1'h1);
        st(32'h162_E4_E_0_0);
        st(32'h042_E4_1_0_1);
        chk(pd_offset, 16'h0000);
        chk(hitless_ok, 1'h0);
        chk(osc_route, 1'h0);
        st(32'h148_E4_0_0_2);
        st(32'h14B_E4_1_0_2);
        finish_test;
    end
endmodule
bind ics_selector ics_selector_chk u_ics_selector_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .alarm_pin(alarm_pin),
    .osc_loss_alarm(osc_loss_alarm), .cal_done(cal_done), .phase_in(phase_in),
    .osc_phase(osc_phase), .ref_sel(ref_sel), .hold_active(hold_active),
    .second_input_status_pin(second_input_status_pin), .pd_offset(pd_offset),
    .hitless_ok(hitless_ok));
`default_nettype wire

// ===== verification/ics_src_model.sv
// Purpose: Upstream sources seen as alarm lines and phase words
// Assumes: Bench changes fault requests just after a rising edge
// Notes: Phases hold still, as if every source ran on frequency
`default_nettype none
module ics_src_model
    import ics_pkg::*;
(
    input wire logic [3:0] los_req, // Inputs losing signal
    input wire logic [3:0] fos_req, // Inputs off frequency
    input wire logic osc_req, // Oscillator failing
    output ics_alarm_t alarm_pin, // Alarm lines
    output logic osc_loss_alarm, // Oscillator alarm
    output logic [4*ICS_PH_W-1:0] phase_in, // Input phases
    output logic [ICS_PH_W-1:0] osc_phase // Oscillator phase
);
    timeunit 1ns;
    timeprecision 1ps;
    // Alarms follow requests at once
    assign alarm_pin = '{los: los_req, fos: fos_req};
    assign osc_loss_alarm = osc_req;
    // Matched detector rates keep every word still
    assign phase_in = 64'h4444_3333_2222_1111;
    assign osc_phase = 16'h5A5A;
endmodule
`default_nettype wire
